// ===== src/fcl_status_leds.sv
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`include "fcl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fcl_status_leds #(
  parameter int unsigned FLASH_HALF_CYC = `FCL_FLASH_HALF_CYC,
  parameter int unsigned SELFTEST_CYC   = `FCL_SELFTEST_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire fcl_pkg::fcl_core_type core_in,
  output logic                       led_ready,
  output logic                       led_run,
  output logic                       led_status,
  output logic                       led_error
);

  fcl_pkg::fcl_state_type state_r;
  fcl_pkg::fcl_state_type state_nxt;
  logic [`FCL_CTRL_WIDTH-1:0] ctrl_r;
  logic [31:0] presc_r;
  logic        tick_r;
  logic        sq_r;
  logic [2:0]  patt_idx_r;
  logic [15:0] test_cnt_r;
  logic        ack_r;
  logic [31:0] dark_cnt_r;
  fcl_pkg::fcl_leds_type leds_r;
  fcl_pkg::fcl_leds_type leds_nxt;

  // Avalon slave: one wait cycle, then answer
  wire       acc      = (avs_read | avs_write) & ~ack_r;
  wire       wr_ctrl  = avs_write & ~ack_r & (avs_address == `FCL_REG_CTRL) & avs_byteenable[0];
  wire [7:0] irreg_pat = `FCL_IRREG_PATTERN;
  wire       irreg    = irreg_pat[patt_idx_r];
  wire       cfg_done = ctrl_r[`FCL_CTRL_CFG_VALID] & ctrl_r[`FCL_CTRL_MODE_SET];
  wire       is_master = ctrl_r[`FCL_CTRL_MASTER];
  wire       in_cfg    = (state_r == fcl_pkg::ST_INIT) | (state_r == fcl_pkg::ST_ACTIVE);
  wire [`FCL_CTRL_WIDTH-1:0] wr_ctrl_data = avs_writedata[`FCL_CTRL_WIDTH-1:0];

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    case (a)
      `FCL_REG_CTRL:   rd_mux = {26'h0, ctrl_r};
      `FCL_REG_STATUS: rd_mux = {27'h0, state_r};
      `FCL_REG_LEDS:   rd_mux = {28'h0, leds_r};
      default:         rd_mux = 32'h0;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      ack_r           <= acc;
      avs_waitrequest <= ~acc;
      avs_readdata    <= (acc & avs_read) ? rd_mux(avs_address) : 32'h0;
    end
  end

  // Length of the current dark stretch of ready while functional
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      dark_cnt_r <= 32'h0;
    else if (led_ready || !in_cfg)
      dark_cnt_r <= 32'h0;
    else
      dark_cnt_r <= dark_cnt_r + 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `FCL_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= avs_writedata[`FCL_CTRL_WIDTH-1:0];
    end
  end

  // Shared prescaler for both flash styles
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      presc_r    <= 32'h0;
      tick_r     <= 1'b0;
      sq_r       <= 1'b0;
      patt_idx_r <= 3'h0;
    end else begin
      tick_r <= (presc_r == FLASH_HALF_CYC - 1);
      presc_r <= (presc_r == FLASH_HALF_CYC - 1) ? 32'h0 : presc_r + 32'h1;
      if (tick_r) begin
        sq_r       <= ~sq_r;
        patt_idx_r <= patt_idx_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      test_cnt_r <= 16'h0;
    else if (state_r == fcl_pkg::ST_TEST)
      test_cnt_r <= test_cnt_r + 16'h1;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fcl_pkg::ST_RESET:  state_nxt = fcl_pkg::ST_TEST;
      fcl_pkg::ST_TEST: begin
        if (core_in.selftest_done && test_cnt_r >= SELFTEST_CYC[15:0])
          state_nxt = core_in.selftest_pass ? fcl_pkg::ST_INIT : fcl_pkg::ST_FAIL;
      end
      fcl_pkg::ST_FAIL:   state_nxt = fcl_pkg::ST_FAIL;
      fcl_pkg::ST_INIT:   if (cfg_done) state_nxt = fcl_pkg::ST_ACTIVE;
      fcl_pkg::ST_ACTIVE: if (!cfg_done) state_nxt = fcl_pkg::ST_INIT;
      default:            state_nxt = fcl_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      state_r <= fcl_pkg::ST_RESET;
    else
      state_r <= state_nxt;
  end

  always_comb begin
    leds_nxt = '0;
    case (state_r)
      fcl_pkg::ST_FAIL: leds_nxt.ready = sq_r;
      fcl_pkg::ST_INIT, fcl_pkg::ST_ACTIVE: begin
        if (ctrl_r[`FCL_CTRL_SYS_ERROR])
          leds_nxt.ready = irreg;
        else if (ctrl_r[`FCL_CTRL_BOOTLOADER])
          leds_nxt.ready = sq_r;
        else
          leds_nxt.ready = 1'b1;
        if (state_r == fcl_pkg::ST_ACTIVE) begin
          if (ctrl_r[`FCL_CTRL_CFG_ERROR])
            leds_nxt.run = irreg;
          else if (core_in.comm_active)
            leds_nxt.run = 1'b1;
          else
            leds_nxt.run = sq_r;
          leds_nxt.status = is_master ? core_in.token_held
                                      : core_in.data_exchange;
        end else begin
          leds_nxt.run = ctrl_r[`FCL_CTRL_CFG_ERROR] ? irreg : 1'b0;
        end
        leds_nxt.error = core_in.bus_error;
      end
      default: leds_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      leds_r <= '0;
    else
      leds_r <= leds_nxt;
  end

  assign led_ready  = leds_r.ready;
  assign led_run    = leds_r.run;
  assign led_status = leds_r.status;
  assign led_error  = leds_r.error;

  AST_RUN_OFF_INIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT && !ctrl_r[`FCL_CTRL_CFG_ERROR] |=> !led_run)
    else $error("run lit during init");
  AST_READY_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && ctrl_r[5:3] == 3'h0 |=> led_ready)
    else $error("ready not on");
  AST_FAIL_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_FAIL |=> state_r == fcl_pkg::ST_FAIL && !led_run)
    else $error("left fail state");
  AST_RUN_COMM: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && !ctrl_r[`FCL_CTRL_CFG_ERROR] && core_in.comm_active
    |=> led_run)
    else $error("run not lit with comm");
  AST_ERROR_LED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == fcl_pkg::ST_ACTIVE) |=> led_error == $past(core_in.bus_error))
    else $error("error led mismatch");
  AST_STATUS_SLAVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && !is_master |=> led_status == $past(core_in.data_exchange))
    else $error("slave status mismatch");
  AST_STATUS_MASTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && is_master |=> led_status == $past(core_in.token_held))
    else $error("master status mismatch");
  AST_SQUARE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_r |=> sq_r != $past(sq_r))
    else $error("square wave not toggled");
  AST_ACTIVE_CFG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT && $rose(state_nxt == fcl_pkg::ST_ACTIVE) |-> cfg_done)
    else $error("active without config");
  AST_RESET_DARK: assert property (@(posedge clk_sys) !rst_n |=> !led_run && !led_ready)
    else $error("leds lit after reset");

  // Bus handshake checks
  AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");

  AST_WAIT_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer cycle");

  AST_CTRL_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && avs_waitrequest && avs_address == `FCL_REG_CTRL && avs_byteenable[0]
    |=> ctrl_r == $past(wr_ctrl_data))
    else $error("control write lost");

  AST_CTRL_RO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && avs_address != `FCL_REG_CTRL |=> $stable(ctrl_r))
    else $error("control changed by other address");

  // Indicator, state and prescaler checks
  AST_RUN_CFG_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && ctrl_r[`FCL_CTRL_CFG_ERROR] |=> led_run == $past(irreg))
    else $error("run not irregular on config error");

  AST_RUN_INIT_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT && ctrl_r[`FCL_CTRL_CFG_ERROR] |=> led_run == $past(irreg))
    else $error("run not irregular on missing config");

  AST_RUN_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_ACTIVE && !ctrl_r[`FCL_CTRL_CFG_ERROR] && !core_in.comm_active
    |=> led_run == $past(sq_r))
    else $error("run not regular while idle");

  AST_READY_BOOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_cfg && !ctrl_r[`FCL_CTRL_SYS_ERROR] && ctrl_r[`FCL_CTRL_BOOTLOADER]
    |=> led_ready == $past(sq_r))
    else $error("ready not regular in bootloader");

  AST_READY_SYSERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_cfg && ctrl_r[`FCL_CTRL_SYS_ERROR] |=> led_ready == $past(irreg))
    else $error("ready not irregular on system error");

  AST_READY_INIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT && ctrl_r[5:3] == 3'h0 |=> led_ready)
    else $error("ready not on during init");

  AST_FAIL_FLASH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_FAIL |=> led_ready == $past(sq_r))
    else $error("ready not flashing after failed test");

  AST_RUN_EARLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !in_cfg |=> !led_run && !led_status)
    else $error("run or status lit before init");

  AST_STATUS_INIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT |=> !led_status)
    else $error("status lit while not configured");

  AST_ERR_INIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_INIT |=> led_error == $past(core_in.bus_error))
    else $error("error led mismatch in init");

  AST_TEST_MIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_TEST && test_cnt_r < SELFTEST_CYC |=> state_r == fcl_pkg::ST_TEST)
    else $error("self-test ended early");

  AST_TEST_DARK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == fcl_pkg::ST_TEST |=> !led_ready && !led_run && !led_error)
    else $error("indicator lit during self-test");

  AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot(state_r))
    else $error("state not one-hot");

  AST_PRESC_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    presc_r < FLASH_HALF_CYC)
    else $error("prescaler out of range");

  // Longest legal dark stretch is two irregular steps plus one partial step
  AST_READY_NOT_DARK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dark_cnt_r <= 32'(3 * FLASH_HALF_CYC))
    else $error("ready dark too long while functional");

endmodule // fcl_status_leds
`default_nettype wire

// ===== common/fcl_params.svh
`ifndef FCL_PARAMS_SVH
`define FCL_PARAMS_SVH
// Register byte offsets
`define FCL_REG_CTRL     4'h0
`define FCL_REG_STATUS   4'h4
`define FCL_REG_LEDS     4'h8
// Control register fields
`define FCL_CTRL_CFG_VALID   0
`define FCL_CTRL_MODE_SET    1
`define FCL_CTRL_MASTER      2
`define FCL_CTRL_BOOTLOADER  3
`define FCL_CTRL_CFG_ERROR   4
`define FCL_CTRL_SYS_ERROR   5
`define FCL_CTRL_WIDTH       6
`define FCL_CTRL_RESET       6'h00
// Flash timing
`define FCL_FLASH_HALF_MS    250
`define FCL_CLK_MHZ          100
`define FCL_FLASH_HALF_CYC   (`FCL_FLASH_HALF_MS * 1000 * `FCL_CLK_MHZ)
`define FCL_SELFTEST_CYC     16
`define FCL_IRREG_PATTERN    8'hB2
`endif

// ===== common/fcl_pkg.sv
`default_nettype none
package fcl_pkg;
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_TEST   = 5'h02,
    ST_FAIL   = 5'h04,
    ST_INIT   = 5'h08,
    ST_ACTIVE = 5'h10
  } fcl_state_type;

  typedef struct packed {
    logic ready;
    logic run;
    logic status;
    logic error;
  } fcl_leds_type;

  typedef struct packed {
    logic selftest_done;
    logic selftest_pass;
    logic comm_active;
    logic data_exchange;
    logic token_held;
    logic bus_error;
  } fcl_core_type;
endpackage
`default_nettype wire

// ===== bench/fcl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_core_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  pass,
  input  wire logic [3:0]            flags,
  output wire fcl_pkg::fcl_core_type core
);
  logic [4:0] cnt_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) cnt_r <= 5'h00;
    else if (cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
  end
  // Self-test verdict only once the count expires
  assign core = {cnt_r == 5'h1F, pass, flags};
endmodule // fcl_core_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clk_sys, rst_n, pass, rd, wr, wt, l_rdy, l_run, l_st, l_err;
  logic [3:0]            adr, flags;
  logic [31:0]           wdat, rdat, got;
  fcl_pkg::fcl_core_type core;
  int                    n_fail = 0, samples_checked = 0;
  wire  [3:0]            leds = {l_rdy, l_run, l_st, l_err};
  // Control, flags {comm,dx,tok,err}, expected leds
  logic [13:0] rows [5] = '{{6'h03, 4'hC, 4'hE}, {6'h07, 4'hA, 4'hE},
    {6'h07, 4'hC, 4'hC}, {6'h03, 4'h9, 4'hD}, {6'h01, 4'h0, 4'h8}};
  fcl_core_model fcl_core_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .pass(pass),
    .flags(flags), .core(core));
  fcl_status_leds #(.FLASH_HALF_CYC(4)) fcl_status_leds_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt), .core_in(core),
    .led_ready(l_rdy), .led_run(l_run), .led_status(l_st), .led_error(l_err));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d = 32'h0);
    @(posedge clk_sys);
    rd <= !w; wr <= w; adr <= a; wdat <= d;
    do @(negedge clk_sys); while (wt !== 1'b0);
    got = rdat;
    @(posedge clk_sys);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic flash(input int i, input string nm);
    int t;
    logic p;
    t = 0;
    p = leds[i];
    repeat (64) begin
      @(negedge clk_sys);
      t += int'(leds[i] !== p);
      p = leds[i];
    end
    check(nm, 32'(t >= 4), 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100us;
    n_fail++;
    test_done;
  end
  initial begin
    rst_n = 1'b0; pass = 1'b1; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0; flags = 4'h0;
    repeat (16) @(negedge clk_sys);
    check("rst_leds", 32'(leds), 32'h0);
    check("rst_wait", 32'(wt), 32'h1);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (60) @(negedge clk_sys);
    check("ready_on", 32'(leds), 32'h8);
    bus(1'b0, 4'h4);
    check("init_state", got, 32'h08);
    bus(1'b1, 4'h0, 32'h01);
    bus(1'b1, 4'h0, 32'h03);
    foreach (rows[k]) begin
      flags <= rows[k][7:4];
      bus(1'b1, 4'h0, 32'(rows[k][13:8]));
      repeat (6) @(negedge clk_sys);
      check("leds", 32'(leds), 32'(rows[k][3:0]));
      bus(1'b0, 4'h8);
      check("leds_reg", got, 32'(rows[k][3:0]));
      $display("row %0d done", k);
    end
    flags <= 4'h0;
    bus(1'b1, 4'h0, 32'h03);
    flash(2, "run_regular");
    bus(1'b1, 4'h0, 32'h11);
    flash(2, "run_irregular");
    bus(1'b1, 4'h0, 32'h0B);
    flash(3, "rdy_boot");
    bus(1'b1, 4'h0, 32'h23);
    flash(3, "rdy_syserr");
    bus(1'b1, 4'h4, 32'h05);
    bus(1'b0, 4'h4);
    check("status_ro", got, 32'h10);
    bus(1'b0, 4'hC);
    check("unmapped", got, 32'h0);
    $display("flash tests done");
    rst_n <= 1'b0;
    pass <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (60) @(negedge clk_sys);
    flash(3, "rdy_fail");
    bus(1'b1, 4'h0, 32'h03);
    repeat (4) @(negedge clk_sys);
    bus(1'b0, 4'h4);
    check("fail_stuck", got, 32'h04);
    $display("fail test done");
    test_done;
  end
endmodule // tb
`default_nettype wire
